// file: hw/adc_port_pkg.sv
// Shared constants and types for the converter serial frame port
package adc_port_pkg;
  // Word length of every framed transfer
  localparam int WORD_BITS = 24;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] WORD_BITS_CNT = 5'h18;
  // Self-clocking shift clock timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF_CNT_W = 4;
  // Control register layout and reset value
  localparam int CTRL_OPMODE_MSB = 23;
  localparam int CTRL_OPMODE_LSB = 21;
  localparam int CTRL_UNIPOLAR_BIT = 12;
  localparam logic [WORD_BITS-1:0] CTRL_RESET = 24'h000000;
  localparam logic [2:0] OPMODE_NORMAL = 3'h0;
  // Buffer shape
  localparam int RESULT_FIFO_DEPTH = 8;

  // Outside pins, sampled together through the synchroniser
  typedef struct packed {
    logic wfs_n;
    logic rfs_n;
    logic mode;
    logic sclk;
    logic io;
    logic sel;
  } pins_t;

  localparam pins_t PINS_RESET = '{wfs_n: 1'b1, rfs_n: 1'b1, mode: 1'b0,
                                   sclk: 1'b0, io: 1'b0, sel: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } port_state_t;

  // All state of the port
  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    pins_t last;
    port_state_t st;
    logic sclk;
    logic [HALF_CNT_W-1:0] half_cnt;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [WORD_BITS-1:0] shreg;
    logic io_out;
    logic io_oe;
    logic ready_n;
    logic [WORD_BITS-1:0] result;
    logic [WORD_BITS-1:0] ctrl;
    logic ctrl_load;
    logic [WORD_BITS-1:0] cal;
    logic cal_load;
    logic sel;
  } port_regs_t;
endpackage : adc_port_pkg

// file: hw/adc_serial_frame_port.sv
// Result FIFO and serial frame port of the measurement converter
`timescale 1ns/1ps

module result_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_regs_t;
  logic [WIDTH-1:0] mem [DEPTH];
  fifo_regs_t r_reg, r_next;
  logic push, pop;

  // Handshakes and pointer update
  always_comb begin
    in_ready = (r_reg.cnt != (PW+1)'(DEPTH));
    out_valid = (r_reg.cnt != '0);
    out_data = mem[r_reg.rp];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    r_next = r_reg;
    if (push) begin
      r_next.wp = (r_reg.wp == PW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = (r_reg.rp == PW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
    end
    r_next.cnt = r_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Storage and pointer registers
  always_ff @(posedge clk) begin
    if (push) begin
      mem[r_reg.wp] <= in_data;
    end
    if (srst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : result_fifo

// What this block does
// - Self-clocking: shift clock starts only after a write or read strobe falls.
// - Self-clocking: read strobe low makes device drive clock and data.
// - External clocking: read strobe low makes device drive data only.
// - Result-ready goes low when a new result word is available.
// - Result-ready returns high after a full result word is shifted out.
// - Result-ready also goes low when calibration finishes.
// - Result reads drive data only after read strobe low and ready low.
// - Write data captured on shift clock rising edges during write strobe.
// - Results: natural binary unipolar, offset binary bipolar.
// - Data line writes control and calibration, reads those and results.
// - Only full 24-bit writes load; clocks past the 24th are ignored.
module adc_serial_frame_port
  import adc_port_pkg::*;
#(
  parameter int FIFO_DEPTH = RESULT_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic self_clock_mode,
  input wire logic register_select,
  input wire logic write_frame_strobe_n,
  input wire logic read_frame_strobe_n,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic serial_io_in,
  output logic serial_io_out,
  output logic serial_io_oe,
  output logic result_ready_n,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [WORD_BITS-1:0] result_code,
  input wire logic cal_done,
  input wire logic [WORD_BITS-1:0] cal_read_data,
  output logic [WORD_BITS-1:0] ctrl_word,
  output logic ctrl_load,
  output logic [WORD_BITS-1:0] cal_write_data,
  output logic cal_load
);
  port_regs_t r_reg, r_next;
  pins_t pins;
  logic fifo_valid, fifo_pop;
  logic [WORD_BITS-1:0] fifo_code, coded;
  logic self_mode, tick, clk_run, rise, fall;
  logic wfs_fall, rfs_fall, wfs_high, rfs_high, full;

  // Pin bundle entering the synchroniser
  assign pins = '{wfs_n: write_frame_strobe_n, rfs_n: read_frame_strobe_n,
                  mode: self_clock_mode, sclk: sclk_in, io: serial_io_in,
                  sel: register_select};

  // Buffer between the converter and the port
  result_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_code),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_code)
  );

  // Edge and clock events derived from synchronised pins
  always_comb begin
    self_mode = r_reg.sync2.mode;
    wfs_fall = r_reg.last.wfs_n & ~r_reg.sync2.wfs_n;
    rfs_fall = r_reg.last.rfs_n & ~r_reg.sync2.rfs_n;
    wfs_high = r_reg.sync2.wfs_n;
    rfs_high = r_reg.sync2.rfs_n;
    full = (r_reg.bit_cnt == WORD_BITS_CNT);
    tick = (r_reg.half_cnt == HALF_CNT_W'(SCLK_HALF_CYCLES - 1));
    // Self clock keeps running until the last low phase is restored
    clk_run = (r_reg.st != ST_IDLE) & (~full | r_reg.sclk);
    if (self_mode) begin
      rise = clk_run & tick & ~r_reg.sclk;
      fall = clk_run & tick & r_reg.sclk;
    end else begin
      rise = ~r_reg.last.sclk & r_reg.sync2.sclk;
      fall = r_reg.last.sclk & ~r_reg.sync2.sclk;
    end
  end

  // Output coding: two's complement in, unipolar or offset binary out
  always_comb begin
    coded = fifo_code;
    if (!r_reg.ctrl[CTRL_UNIPOLAR_BIT]) begin
      coded[WORD_BITS-1] = ~fifo_code[WORD_BITS-1];
    end
  end

  // New result accepted only while the previous one has been consumed
  assign fifo_pop = fifo_valid & r_reg.ready_n & (r_reg.st == ST_IDLE);

  // Next-state logic of the port
  always_comb begin
    r_next = r_reg;
    r_next.sync1 = pins;
    r_next.sync2 = r_reg.sync1;
    r_next.last = r_reg.sync2;
    r_next.ctrl_load = 1'b0;
    r_next.cal_load = 1'b0;
    // Self-clock divider runs only inside a frame
    if (self_mode & clk_run) begin
      r_next.half_cnt = tick ? '0 : r_reg.half_cnt + 1'b1;
      if (tick) begin
        r_next.sclk = ~r_reg.sclk;
      end
    end else begin
      r_next.half_cnt = '0;
      r_next.sclk = 1'b0;
    end
    if (fifo_pop) begin
      r_next.result = coded;
      r_next.ready_n = 1'b0;
    end
    case (r_reg.st)
      ST_IDLE: begin
        r_next.bit_cnt = '0;
        r_next.io_oe = 1'b0;
        if (wfs_fall) begin
          r_next.st = ST_WRITE;
          r_next.sel = r_reg.sync2.sel;
        end else if (rfs_fall) begin
          r_next.sel = r_reg.sync2.sel;
          if (!r_reg.sync2.sel) begin
            r_next.shreg = r_reg.ctrl;
            r_next.st = ST_READ;
          end else if (r_reg.ctrl[CTRL_OPMODE_MSB:CTRL_OPMODE_LSB]
                       != OPMODE_NORMAL) begin
            r_next.shreg = cal_read_data;
            r_next.st = ST_READ;
          end else if (!r_reg.ready_n) begin
            r_next.shreg = r_reg.result;
            r_next.st = ST_READ;
          end
          if (r_next.st == ST_READ) begin
            r_next.io_oe = 1'b1;
            r_next.io_out = r_next.shreg[WORD_BITS-1];
          end
        end
      end
      ST_WRITE: begin
        if (rise & ~full) begin
          r_next.shreg = {r_reg.shreg[WORD_BITS-2:0],
                          r_reg.sync2.io};
          r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
        end
        if (wfs_high) begin
          r_next.st = ST_IDLE;
          r_next.sclk = 1'b0; // A cut frame must not leave the clock high
          if (full & ~r_reg.sel) begin
            r_next.ctrl = r_reg.shreg;
            r_next.ctrl_load = 1'b1;
          end else if (full) begin
            r_next.cal = r_reg.shreg;
            r_next.cal_load = 1'b1;
          end
        end
      end
      ST_READ: begin
        if (rise & ~full) begin
          r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
          if ((r_reg.bit_cnt == WORD_BITS_CNT - 1'b1) & r_reg.sel &
              (r_reg.ctrl[CTRL_OPMODE_MSB:CTRL_OPMODE_LSB]
               == OPMODE_NORMAL)) begin
            r_next.ready_n = 1'b1;
          end
        end
        if (fall & ~full) begin
          r_next.shreg = {r_reg.shreg[WORD_BITS-2:0], 1'b0};
          r_next.io_out = r_reg.shreg[WORD_BITS-2];
        end
        if (rfs_high) begin
          r_next.st = ST_IDLE;
          r_next.sclk = 1'b0; // A cut frame must not leave the clock high
          r_next.io_oe = 1'b0;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
        r_next.io_oe = 1'b0;
      end
    endcase
    // Calibration end wins over a clear in the same cycle
    if (cal_done) begin
      r_next.ready_n = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg <= '{sync1: PINS_RESET, sync2: PINS_RESET, last: PINS_RESET,
                 st: ST_IDLE, ready_n: 1'b1, ctrl: CTRL_RESET,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Pin and user-side outputs
  assign sclk_out = r_reg.sclk;
  assign sclk_oe = self_mode & (r_reg.st != ST_IDLE);
  assign serial_io_out = r_reg.io_out;
  assign serial_io_oe = r_reg.io_oe;
  assign result_ready_n = r_reg.ready_n;
  assign ctrl_word = r_reg.ctrl;
  assign ctrl_load = r_reg.ctrl_load;
  assign cal_write_data = r_reg.cal;
  assign cal_load = r_reg.cal_load;
endmodule : adc_serial_frame_port

// file: verif/adc_port_properties.sv
// Pin-level checks of the converter serial frame port
`timescale 1ns/1ps
module adc_port_properties
  import adc_port_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic self_clock_mode,
  input wire logic register_select,
  input wire logic write_frame_strobe_n,
  input wire logic read_frame_strobe_n,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic serial_io_oe,
  input wire logic result_ready_n,
  input wire logic cal_done,
  input wire logic [WORD_BITS-1:0] ctrl_word,
  input wire logic ctrl_load
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Shift clock ownership and idle level
  a_ext_clock_quiet: assert property (
    !self_clock_mode [*5] |-> !sclk_oe) else $error("sclk driven");
  a_sclk_in_frame: assert property (
    $rose(sclk_oe) |-> self_clock_mode &&
    !(read_frame_strobe_n && write_frame_strobe_n)) else $error("sclk");
  a_sclk_idle_low: assert property (
    !sclk_oe |-> !sclk_out) else $error("sclk not low");
  a_self_read_start: assert property (
    self_clock_mode && $fell(read_frame_strobe_n) &&
    (!register_select || !result_ready_n) |->
    ##[3:6] (sclk_oe && serial_io_oe)) else $error("no read start");
  // Data line direction
  a_io_after_read: assert property (
    $rose(serial_io_oe) |-> !read_frame_strobe_n && write_frame_strobe_n)
    else $error("io driven early");
  a_io_quiet_write: assert property (
    !write_frame_strobe_n [*4] |-> !serial_io_oe) else $error("io in write");
  // Result-ready behaviour
  a_cal_sets_ready: assert property (
    cal_done |=> !result_ready_n) else $error("cal not flagged");
  a_ready_holds: assert property (
    !result_ready_n && !serial_io_oe |=> !result_ready_n)
    else $error("ready dropped");
  a_ready_clears: assert property (
    $rose(result_ready_n) |-> serial_io_oe && !read_frame_strobe_n)
    else $error("ready cleared outside read");
  // Control word loads only at the end of a write frame
  a_ctrl_commit: assert property (
    $changed(ctrl_word) |-> ctrl_load && write_frame_strobe_n)
    else $error("ctrl changed without load");
endmodule : adc_port_properties

bind adc_serial_frame_port adc_port_properties adc_port_properties_i (
  .clk(clk),
  .srst(srst),
  .self_clock_mode(self_clock_mode),
  .register_select(register_select),
  .write_frame_strobe_n(write_frame_strobe_n),
  .read_frame_strobe_n(read_frame_strobe_n),
  .sclk_out(sclk_out),
  .sclk_oe(sclk_oe),
  .serial_io_oe(serial_io_oe),
  .result_ready_n(result_ready_n),
  .cal_done(cal_done),
  .ctrl_word(ctrl_word),
  .ctrl_load(ctrl_load)
);

// file: verif/host_model.sv
// Host controller model: frame strobes, shift clock and data line
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic sclk_line,
  input wire logic io_line,
  output logic wfs_n,
  output logic rfs_n,
  output logic sclk_h,
  output logic io_h,
  output logic io_h_oe
);
  // Idle pins; shift clock stands low between frames
  initial begin
    {wfs_n, rfs_n, sclk_h, io_h, io_h_oe} = 5'h18;
  end
  // Bounded wait for the device shift clock
  task automatic wait_sclk(input logic lv, inout bit tmo);
    for (int k = 0; k < 40 && sclk_line !== lv; k++) @(negedge clk);
    if (sclk_line !== lv) tmo = 1'b1;
  endtask : wait_sclk
  // One frame; only one strobe is ever low at a time
  task automatic frame(input bit wr, input bit sm, input int n,
                       input logic [23:0] w, output logic [23:0] r,
                       inout bit tmo);
    r = 24'h0;
    #7;
    if (wr) wfs_n = 1'b0;
    else rfs_n = 1'b0;
    io_h_oe = wr;
    // First bit stands before the device's own first clock edge
    io_h = w[23];
    #160;
    for (int i = 0; i < n; i++) begin
      io_h = w[23 - (i % 24)];
      if (sm) begin
        wait_sclk(1'b1, tmo);
        r = {r[22:0], io_line};
        wait_sclk(1'b0, tmo);
      end else begin
        #80 sclk_h = 1'b1;
        // Late sample: device data lags the clock through its synchroniser
        #79 r = {r[22:0], io_line};
        #1 sclk_h = 1'b0;
      end
    end
    #160;
    {wfs_n, rfs_n, io_h_oe} = 3'h6;
    #160;
  endtask : frame
endmodule : host_model

// file: verif/adc_serial_frame_port_tb.sv
// Self-checking bench of the converter serial frame port
`timescale 1ns/1ps
module adc_serial_frame_port_tb;
  import adc_port_pkg::*;
  logic clk = 1'b0, srst = 1'b1, mode = 1'b0, sel = 1'b0, rv = 1'b0;
  logic cal_done = 1'b0, io_last = 1'b0;
  logic [23:0] code = 24'h0, cal_rd = 24'h0, ctrl_m, w, r, cw, cd;
  logic wfs_n, rfs_n, sclk_h, io_h, io_h_oe, so, soe, io_o, io_oe;
  logic rdy_n, r_rdy, c_ld, k_ld;
  int n_fail = 0, samples_checked = 0, n_c = 0, n_k = 0;
  logic [23:0] q[$];
  wire sclk_line = soe ? so : sclk_h;
  wire io_line = io_oe ? io_o : io_h_oe ? io_h : ~io_last;
  always #10 clk = ~clk;
  // Released line toggles; load pulses are counted
  always @(posedge clk) begin
    io_last <= io_line;
    if (c_ld === 1'b1) n_c++;
    if (k_ld === 1'b1) n_k++;
  end
  adc_serial_frame_port #(.FIFO_DEPTH(RESULT_FIFO_DEPTH))
    adc_serial_frame_port_i (.clk(clk), .srst(srst),
    .self_clock_mode(mode), .register_select(sel),
    .write_frame_strobe_n(wfs_n), .read_frame_strobe_n(rfs_n),
    .sclk_in(sclk_line), .sclk_out(so), .sclk_oe(soe),
    .serial_io_in(io_line), .serial_io_out(io_o), .serial_io_oe(io_oe),
    .result_ready_n(rdy_n), .result_valid(rv), .result_ready(r_rdy),
    .result_code(code), .cal_done(cal_done), .cal_read_data(cal_rd),
    .ctrl_word(cw), .ctrl_load(c_ld), .cal_write_data(cd),
    .cal_load(k_ld));
  host_model host_model_i (.clk(clk), .sclk_line(sclk_line),
    .io_line(io_line), .wfs_n(wfs_n), .rfs_n(rfs_n), .sclk_h(sclk_h),
    .io_h(io_h), .io_h_oe(io_h_oe));
  // Verdict and end of run
  task automatic complete_run;
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic guard(input bit bad);
    if (bad) begin
      n_fail++;
      complete_run();
    end
  endtask : guard
  task automatic xfer(input bit wr, input bit sm, input int n,
                      input logic [23:0] d);
    bit tmo;
    tmo = 1'b0;
    host_model_i.frame(wr, sm, n, d, r, tmo);
    guard(tmo);
    @(negedge clk);
  endtask : xfer
  task automatic wait_rdy;
    for (int k = 0; k < 20 && rdy_n !== 1'b0; k++) @(negedge clk);
    guard(rdy_n !== 1'b0);
  endtask : wait_rdy
  // Main sequence
  initial begin
    void'($urandom(38358));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    ctrl_m = ($urandom & 24'h1fffff) | 24'h001000;
    xfer(1, 0, 24, ctrl_m);
    chk(cw, ctrl_m);
    xfer(1, 0, 12, ~ctrl_m);
    chk(cw, ctrl_m);
    chk(n_c, 1);
    ctrl_m = ctrl_m ^ 24'h000f0f;
    xfer(1, 0, 30, ctrl_m);
    chk(cw, ctrl_m);
    sel = 1'b1;
    w = $urandom;
    xfer(1, 0, 24, w);
    chk(cd, w);
    chk(n_k, 1);
    // Fill until refused; one word waits in the output register
    rv = 1'b1;
    for (int i = 0; i < 12; i++) begin
      code = $urandom;
      if (r_rdy === 1'b1) q.push_back(code);
      @(negedge clk);
    end
    rv = 1'b0;
    chk(q.size(), RESULT_FIFO_DEPTH + 1);
    chk(r_rdy, 0);
    // Drain in external clocking, unipolar coding
    for (int i = 0; q.size() > 0 && i < 12; i++) begin
      wait_rdy();
      xfer(0, 0, 24, 24'h0);
      chk(r, q.pop_front());
    end
    repeat (8) @(negedge clk);
    chk(rdy_n, 1);
    sel = 1'b0;
    xfer(0, 0, 24, 24'h0);
    chk(r, ctrl_m);
    // Calibration readback outside normal mode
    ctrl_m = ctrl_m | 24'h200000;
    xfer(1, 0, 24, ctrl_m);
    cal_rd = $urandom;
    sel = 1'b1;
    xfer(0, 0, 24, 24'h0);
    chk(r, cal_rd);
    // Bipolar result read in self-clocking mode
    sel = 1'b0;
    ctrl_m = ctrl_m & 24'h1fefff;
    xfer(1, 0, 24, ctrl_m);
    mode = 1'b1;
    rv = 1'b1;
    code = $urandom;
    @(negedge clk);
    rv = 1'b0;
    wait_rdy();
    sel = 1'b1;
    xfer(0, 1, 24, 24'h0);
    chk(r, code ^ 24'h800000);
    // Control write on the device's own shift clock
    sel = 1'b0;
    ctrl_m = ctrl_m ^ 24'h0000f0;
    xfer(1, 1, 24, ctrl_m);
    chk(cw, ctrl_m);
    cal_done = 1'b1;
    @(negedge clk);
    cal_done = 1'b0;
    @(negedge clk);
    chk(rdy_n, 0);
    complete_run();
  end
endmodule : adc_serial_frame_port_tb
